/* logic/pcr_config_regs.sv */
// Plug and play card and logical device configuration register file
`timescale 1ns/1ps
`default_nettype none
module pcr_config_regs
  import pcr_pkg::*;
(
  input wire logic i_clk,
  input wire logic i_rst_n,
  input wire logic i_address_strap_high,
  input wire pcr_io_req_t i_io,
  input wire logic i_key_done,
  input wire logic i_isolation_lost,
  input wire logic [7:0] i_isolation_data,
  input wire logic [7:0] i_resource_byte,
  input wire logic i_resource_valid,
  output logic [7:0] o_rdata,
  output logic o_rdata_valid,
  output var pcr_state_t o_card_state,
  output logic [7:0] o_csn,
  output logic [7:0] o_ldn,
  output logic [9:0] o_read_port,
  output logic o_isolation_step,
  output logic o_resource_next,
  output logic o_resource_rewind,
  output var pcr_ldev_t [LDEV_COUNT-1:0] o_ldev,
  output logic [LDEV_COUNT-1:0] o_irq_selected,
  output logic [LDEV_COUNT-1:0] o_irq_open_drain,
  output logic [LDEV_COUNT-1:0] o_dma0_active,
  output logic [LDEV_COUNT-1:0] o_dma1_active
);

  // ----------------------------------------
  // State
  // ----------------------------------------
  logic init_done;
  logic pnp_mode;
  logic [7:0] index;
  pcr_state_t next_state;
  logic [7:0] next_rdata;
  logic next_rdata_valid;

  // ----------------------------------------
  // Port decode
  // ----------------------------------------
  wire [11:0] addr12 = i_io.addr[11:0];
  wire [7:0] wdata = i_io.wdata;
  wire st_wait = (o_card_state == ST_WAIT_KEY);
  wire st_sleep = (o_card_state == ST_SLEEP);
  wire st_iso = (o_card_state == ST_ISOLATION);
  wire st_cfg = (o_card_state == ST_CONFIG);
  wire awake = !st_wait;

  // Isolation mode decodes only the low twelve address lines
  wire isa_idx = (addr12 == ISA_INDEX_ADDR);
  wire isa_wdat = (addr12 == ISA_WDATA_ADDR);
  wire isa_rdat = (addr12 == {2'h0, o_read_port});
  wire mb_idx = (i_io.addr == MB_INDEX_ADDR);
  wire mb_dat = (i_io.addr == MB_DATA_ADDR);

  wire idx_wr = init_done && i_io.wr && (pnp_mode ? isa_idx : mb_idx);
  wire dat_wr = init_done && i_io.wr && (pnp_mode ? isa_wdat : mb_dat);
  // Index port is write-only in isolation mode
  wire idx_rd = init_done && i_io.rd && !pnp_mode && mb_idx;
  wire dat_rd = init_done && i_io.rd && awake && (pnp_mode ? isa_rdat : mb_dat);

  // ----------------------------------------
  // Register write strobes
  // ----------------------------------------
  wire wr_rdport = dat_wr && st_iso && (index == IDX_RDPORT);
  wire wr_cc = dat_wr && awake && (index == IDX_CFG_CTRL);
  wire wr_wake = dat_wr && awake && (index == IDX_WAKE);
  wire wr_csn = dat_wr && (st_iso || st_cfg) && (index == IDX_CSN);
  wire wr_ldn = dat_wr && st_cfg && (index == IDX_LDN);
  wire wr_ldev = dat_wr && st_cfg && (index >= IDX_ACTIVATE);

  // Command bits act only on the write cycle, nothing is stored
  wire soft_rst = wr_cc && wdata[CC_SOFT_RESET_BIT];
  wire cc_wait_key = wr_cc && wdata[CC_WAIT_KEY_BIT];
  wire cc_csn_clear = wr_cc && wdata[CC_CSN_CLEAR_BIT];
  wire wake_match = (wdata == o_csn);

  // ----------------------------------------
  // Register read strobes
  // ----------------------------------------
  wire rd_iso = dat_rd && st_iso && (index == IDX_SERIAL_ISO);
  // Stream only moves when a byte really was offered
  wire rd_res = dat_rd && st_cfg && (index == IDX_RESOURCE) && i_resource_valid;

  // ----------------------------------------
  // Logical devices
  // ----------------------------------------
  logic [LDEV_COUNT-1:0] rc_hit;
  logic [7:0] rc_chain [LDEV_COUNT:0];
  assign rc_chain[LDEV_COUNT] = BYTE_ZERO;

  genvar gi;
  generate
    for (gi = 0; gi < LDEV_COUNT; gi++) begin : g_ldev
      wire sel = (o_ldn == 8'(gi));
      wire [15:0] offs = 16'(i_io.addr - o_ldev[gi].base0);
      wire in_range = (i_io.addr >= o_ldev[gi].base0) && (offs < IO_RANGE_LEN);
      wire [7:0] pat = o_ldev[gi].rc_pattern ? RC_PATTERN_ONE : RC_PATTERN_ZERO;

      pcr_ldev_regs u_regs (
        .i_clk(i_clk),
        .i_rst_n(i_rst_n),
        .i_soft_rst(soft_rst),
        .i_wr(wr_ldev && sel),
        .i_index(index),
        .i_wdata(wdata),
        .o_regs(o_ldev[gi])
      );

      // Check only counts while the device is off the bus
      assign rc_hit[gi] = o_ldev[gi].rc_enable && !o_ldev[gi].active && in_range;
      // Lowest device number wins an overlap
      assign rc_chain[gi] = rc_hit[gi] ? pat : rc_chain[gi+1];

      always_ff @(posedge i_clk or negedge i_rst_n) begin
        if (!i_rst_n) begin
          o_irq_selected[gi] <= 1'b0;
          o_irq_open_drain[gi] <= 1'b1;
          o_dma0_active[gi] <= 1'b0;
          o_dma1_active[gi] <= 1'b0;
        end else begin
          o_irq_selected[gi] <= (o_ldev[gi].irq_level != IRQ_NONE);
          o_irq_open_drain[gi] <= !o_ldev[gi].irq_type[IRQ_TYPE_HIGH_BIT];
          o_dma0_active[gi] <= (o_ldev[gi].dma0 != DMA_NONE);
          o_dma1_active[gi] <= (o_ldev[gi].dma1 != DMA_NONE);
        end
      end
    end
  endgenerate

  // Range answer yields to the configuration ports themselves
  wire rc_any = init_done && i_io.rd && (|rc_hit) && !dat_rd && !idx_rd;

  // ----------------------------------------
  // Read data selection
  // ----------------------------------------
  wire ldn_ok = (o_ldn < 8'(LDEV_COUNT));
  wire pcr_ldev_t cur = ldn_ok ? o_ldev[o_ldn[3:0]] : LDEV_DEFAULT;

  wire [7:0] ldev_rd =
    (index == IDX_ACTIVATE) ? {7'h00, cur.active} :
    (index == IDX_RANGE_CHK) ? {6'h00, cur.rc_enable, cur.rc_pattern} :
    (index == IDX_BASE0_HI) ? cur.base0[15:8] :
    (index == IDX_BASE0_LO) ? cur.base0[7:0] :
    (index == IDX_BASE1_HI) ? cur.base1[15:8] :
    (index == IDX_BASE1_LO) ? cur.base1[7:0] :
    (index == IDX_IRQ_LEVEL) ? {4'h0, cur.irq_level} :
    (index == IDX_IRQ_TYPE) ? {6'h00, cur.irq_type} :
    (index == IDX_DMA0) ? {5'h00, cur.dma0} :
    (index == IDX_DMA1) ? {5'h00, cur.dma1} : BYTE_ZERO;

  // Write-only registers read back as zero
  wire [7:0] card_rd =
    (index == IDX_SERIAL_ISO) ? (st_iso ? i_isolation_data : BYTE_ZERO) :
    (index == IDX_RESOURCE) ? (st_cfg ? i_resource_byte : BYTE_ZERO) :
    (index == IDX_STATUS) ? (st_cfg ? {7'h00, i_resource_valid} : BYTE_ZERO) :
    (index == IDX_CSN) ? o_csn :
    (index == IDX_LDN) ? o_ldn :
    (st_cfg && index >= IDX_ACTIVATE) ? ldev_rd : BYTE_ZERO;

  assign next_rdata = dat_rd ? card_rd : idx_rd ? index : rc_any ? rc_chain[0] : BYTE_ZERO;
  assign next_rdata_valid = dat_rd || idx_rd || rc_any;

  // ----------------------------------------
  // Card state sequencing
  // ----------------------------------------
  always_comb begin
    next_state = o_card_state;
    case (o_card_state)
      ST_WAIT_KEY: begin
        if (i_key_done) begin
          next_state = ST_SLEEP;
        end
      end
      ST_SLEEP: begin
        if (wr_wake && wake_match) begin
          next_state = (wdata == BYTE_ZERO) ? ST_ISOLATION : ST_CONFIG;
        end
      end
      ST_ISOLATION: begin
        if (i_isolation_lost) begin
          next_state = ST_SLEEP;
        end else if (wr_csn) begin
          next_state = ST_CONFIG;
        end else if (wr_wake && !wake_match) begin
          next_state = ST_SLEEP;
        end
      end
      ST_CONFIG: begin
        if (wr_wake && !wake_match) begin
          next_state = ST_SLEEP;
        end
      end
      default: begin
        next_state = ST_WAIT_KEY;
      end
    endcase
    if (cc_wait_key) begin
      next_state = ST_WAIT_KEY;
    end
  end

  // ----------------------------------------
  // Strap capture and state
  // ----------------------------------------
  // Strap is taken on the first edge after release, not by the reset itself
  always_ff @(posedge i_clk or negedge i_rst_n) begin
    if (!i_rst_n) begin
      init_done <= 1'b0;
      pnp_mode <= 1'b1;
      o_card_state <= ST_WAIT_KEY;
    end else if (!init_done) begin
      init_done <= 1'b1;
      pnp_mode <= !i_address_strap_high;
      o_card_state <= i_address_strap_high ? ST_CONFIG : ST_WAIT_KEY;
    end else begin
      o_card_state <= next_state;
    end
  end

  // ----------------------------------------
  // Card level registers
  // ----------------------------------------
  always_ff @(posedge i_clk or negedge i_rst_n) begin
    if (!i_rst_n) begin
      index <= BYTE_ZERO;
    end else if (idx_wr) begin
      index <= wdata;
    end
  end

  always_ff @(posedge i_clk or negedge i_rst_n) begin
    if (!i_rst_n) begin
      o_read_port <= {BYTE_ZERO, RDPORT_LOW_BITS};
    end else if (wr_rdport) begin
      o_read_port <= {wdata, RDPORT_LOW_BITS};
    end
  end

  // Soft reset leaves the card number alone
  always_ff @(posedge i_clk or negedge i_rst_n) begin
    if (!i_rst_n) begin
      o_csn <= BYTE_ZERO;
    end else if (cc_csn_clear) begin
      o_csn <= BYTE_ZERO;
    end else if (wr_csn) begin
      o_csn <= wdata;
    end
  end

  always_ff @(posedge i_clk or negedge i_rst_n) begin
    if (!i_rst_n) begin
      o_ldn <= BYTE_ZERO;
    end else if (soft_rst) begin
      o_ldn <= BYTE_ZERO;
    end else if (wr_ldn) begin
      o_ldn <= wdata;
    end
  end

  // ----------------------------------------
  // Host answers and stream strobes
  // ----------------------------------------
  always_ff @(posedge i_clk or negedge i_rst_n) begin
    if (!i_rst_n) begin
      o_rdata <= BYTE_ZERO;
      o_rdata_valid <= 1'b0;
      o_isolation_step <= 1'b0;
      o_resource_next <= 1'b0;
      o_resource_rewind <= 1'b0;
    end else begin
      o_rdata <= next_rdata;
      o_rdata_valid <= next_rdata_valid;
      o_isolation_step <= rd_iso;
      o_resource_next <= rd_res;
      o_resource_rewind <= wr_wake;
    end
  end

endmodule
`default_nettype wire

/* logic/pcr_pkg.sv */
// Package of constants and types for the plug and play configuration registers
package pcr_pkg;

  // ----------------------------------------
  // Register indexes
  // ----------------------------------------
  localparam logic [7:0] IDX_RDPORT = 8'h00;
  localparam logic [7:0] IDX_SERIAL_ISO = 8'h01;
  localparam logic [7:0] IDX_CFG_CTRL = 8'h02;
  localparam logic [7:0] IDX_WAKE = 8'h03;
  localparam logic [7:0] IDX_RESOURCE = 8'h04;
  localparam logic [7:0] IDX_STATUS = 8'h05;
  localparam logic [7:0] IDX_CSN = 8'h06;
  localparam logic [7:0] IDX_LDN = 8'h07;
  localparam logic [7:0] IDX_ACTIVATE = 8'h30;
  localparam logic [7:0] IDX_RANGE_CHK = 8'h31;
  localparam logic [7:0] IDX_BASE0_HI = 8'h60;
  localparam logic [7:0] IDX_BASE0_LO = 8'h61;
  localparam logic [7:0] IDX_BASE1_HI = 8'h62;
  localparam logic [7:0] IDX_BASE1_LO = 8'h63;
  localparam logic [7:0] IDX_IRQ_LEVEL = 8'h70;
  localparam logic [7:0] IDX_IRQ_TYPE = 8'h71;
  localparam logic [7:0] IDX_DMA0 = 8'h74;
  localparam logic [7:0] IDX_DMA1 = 8'h75;

  // ----------------------------------------
  // Field positions and values
  // ----------------------------------------
  localparam int CC_SOFT_RESET_BIT = 0;
  localparam int CC_WAIT_KEY_BIT = 1;
  localparam int CC_CSN_CLEAR_BIT = 2;
  localparam int ACT_BIT = 0;
  localparam int RC_PAT_BIT = 0;
  localparam int RC_EN_BIT = 1;
  localparam int IRQ_TYPE_LEVEL_BIT = 0;
  localparam int IRQ_TYPE_HIGH_BIT = 1;
  localparam int IRQ_LVL_W = 4;
  localparam int DMA_W = 3;
  localparam logic [1:0] RDPORT_LOW_BITS = 2'h3;
  localparam logic [3:0] IRQ_NONE = 4'h0;
  localparam logic [2:0] DMA_NONE = 3'h4;
  localparam logic [7:0] RC_PATTERN_ONE = 8'h55;
  localparam logic [7:0] RC_PATTERN_ZERO = 8'hAA;
  localparam logic [7:0] BYTE_ZERO = 8'h00;

  // ----------------------------------------
  // Port addresses and sizes
  // ----------------------------------------
  localparam logic [11:0] ISA_INDEX_ADDR = 12'h279;
  localparam logic [11:0] ISA_WDATA_ADDR = 12'hA79;
  localparam logic [15:0] MB_INDEX_ADDR = 16'h015C;
  localparam logic [15:0] MB_DATA_ADDR = 16'h015D;
  localparam logic [15:0] IO_RANGE_LEN = 16'h0008;
  localparam int LDEV_COUNT = 9;

  // ----------------------------------------
  // Types
  // ----------------------------------------
  typedef enum logic [1:0] {
    ST_WAIT_KEY,
    ST_SLEEP,
    ST_ISOLATION,
    ST_CONFIG
  } pcr_state_t;

  typedef struct packed {
    logic [15:0] addr;
    logic rd;
    logic wr;
    logic [7:0] wdata;
  } pcr_io_req_t;

  typedef struct packed {
    logic active;
    logic rc_enable;
    logic rc_pattern;
    logic [15:0] base0;
    logic [15:0] base1;
    logic [3:0] irq_level;
    logic [1:0] irq_type;
    logic [2:0] dma0;
    logic [2:0] dma1;
  } pcr_ldev_t;

  localparam pcr_ldev_t LDEV_DEFAULT = '{
    active: 1'b0, rc_enable: 1'b0, rc_pattern: 1'b0,
    base0: 16'h0000, base1: 16'h0000, irq_level: IRQ_NONE,
    irq_type: 2'h0, dma0: DMA_NONE, dma1: DMA_NONE
  };

endpackage

/* logic/pcr_ldev_regs.sv */
// Register set of one logical device
`timescale 1ns/1ps
`default_nettype none
module pcr_ldev_regs
  import pcr_pkg::*;
(
  input wire logic i_clk,
  input wire logic i_rst_n,
  input wire logic i_soft_rst,
  input wire logic i_wr,
  input wire logic [7:0] i_index,
  input wire logic [7:0] i_wdata,
  output var pcr_ldev_t o_regs
);

  pcr_ldev_t next_regs;

  // ----------------------------------------
  // Write decode
  // ----------------------------------------
  always_comb begin
    next_regs = o_regs;
    if (i_soft_rst) begin
      next_regs = LDEV_DEFAULT;
    end else if (i_wr) begin
      case (i_index)
        IDX_ACTIVATE: begin
          next_regs.active = i_wdata[ACT_BIT];
        end
        IDX_RANGE_CHK: begin
          next_regs.rc_enable = i_wdata[RC_EN_BIT];
          next_regs.rc_pattern = i_wdata[RC_PAT_BIT];
        end
        IDX_BASE0_HI: begin
          next_regs.base0[15:8] = i_wdata;
        end
        IDX_BASE0_LO: begin
          next_regs.base0[7:0] = i_wdata;
        end
        IDX_BASE1_HI: begin
          next_regs.base1[15:8] = i_wdata;
        end
        IDX_BASE1_LO: begin
          next_regs.base1[7:0] = i_wdata;
        end
        IDX_IRQ_LEVEL: begin
          next_regs.irq_level = i_wdata[IRQ_LVL_W-1:0];
        end
        IDX_IRQ_TYPE: begin
          next_regs.irq_type = i_wdata[1:0];
        end
        IDX_DMA0: begin
          next_regs.dma0 = i_wdata[DMA_W-1:0];
        end
        IDX_DMA1: begin
          next_regs.dma1 = i_wdata[DMA_W-1:0];
        end
        default: begin
          next_regs = o_regs;
        end
      endcase
    end
  end

  always_ff @(posedge i_clk or negedge i_rst_n) begin
    if (!i_rst_n) begin
      o_regs <= LDEV_DEFAULT;
    end else begin
      o_regs <= next_regs;
    end
  end

endmodule
`default_nettype wire

/* bench/pcr_config_regs_sva.sv */
// Concurrent checks on the configuration register file ports
`timescale 1ns/1ps
`default_nettype none
module pcr_config_regs_sva
  import pcr_pkg::*;
(
  input wire logic i_clk,
  input wire logic i_rst_n,
  input wire pcr_io_req_t i_io,
  input wire logic i_key_done,
  input wire logic [7:0] i_resource_byte,
  input wire logic i_resource_valid,
  input wire logic [7:0] o_rdata,
  input wire logic o_rdata_valid,
  input wire pcr_state_t o_card_state,
  input wire logic [7:0] o_csn,
  input wire logic [9:0] o_read_port,
  input wire logic o_isolation_step,
  input wire logic o_resource_next,
  input wire logic o_resource_rewind,
  input wire pcr_ldev_t [LDEV_COUNT-1:0] o_ldev,
  input wire logic [LDEV_COUNT-1:0] o_irq_selected,
  input wire logic [LDEV_COUNT-1:0] o_irq_open_drain,
  input wire logic [LDEV_COUNT-1:0] o_dma0_active
);
  // ----------------------------------------
  // Expected decodes, one cycle ahead of the outputs
  // ----------------------------------------
  logic [LDEV_COUNT-1:0] want_irq;
  logic [LDEV_COUNT-1:0] want_od;
  logic [LDEV_COUNT-1:0] want_dma;
  always_comb begin
    for (int i = 0; i < LDEV_COUNT; i++) begin
      want_irq[i] = o_ldev[i].irq_level != IRQ_NONE;
      want_od[i] = !o_ldev[i].irq_type[IRQ_TYPE_HIGH_BIT];
      want_dma[i] = o_ldev[i].dma0 != DMA_NONE;
    end
  end
  // Index as last written through the isolation-mode index port
  logic [7:0] pnp_index;
  always_ff @(posedge i_clk or negedge i_rst_n) begin
    if (!i_rst_n) begin
      pnp_index <= BYTE_ZERO;
    end else if (i_io.wr && i_io.addr[11:0] == ISA_INDEX_ADDR) begin
      pnp_index <= i_io.wdata;
    end
  end
  // ----------------------------------------
  // Properties
  // ----------------------------------------
  default clocking cb @(posedge i_clk); endclocking
  default disable iff (!i_rst_n);
  sequence s_iso_read;
    o_card_state == ST_ISOLATION && i_io.rd && i_io.addr[11:0] == {2'b00, o_read_port}
      && pnp_index == IDX_SERIAL_ISO;
  endsequence
  sequence s_step_answer;
    o_isolation_step && o_rdata_valid;
  endsequence
  AST_ISO_STEP: assert property (s_iso_read |=> s_step_answer)
    else $error("isolation read gave no step");
  AST_RDPORT_LOAD: assert property ($changed(o_read_port) |-> $past(i_io.wr)
    && $past(o_card_state) == ST_ISOLATION && o_read_port[1:0] == RDPORT_LOW_BITS)
    else $error("read port changed without cause");
  AST_VALID_CAUSE: assert property (o_rdata_valid |-> $past(i_io.rd))
    else $error("read answer without read");
  AST_IDLE_ZERO: assert property (!o_rdata_valid |-> o_rdata == BYTE_ZERO)
    else $error("read data not zero when idle");
  AST_REWIND_CAUSE: assert property (o_resource_rewind |-> $past(i_io.wr)
    && $past(o_card_state) != ST_WAIT_KEY)
    else $error("rewind without wake write");
  AST_RES_BYTE: assert property (o_resource_next |-> o_rdata_valid
    && o_rdata == $past(i_resource_byte) && $past(i_resource_valid))
    else $error("resource byte not presented");
  AST_CSN_WRITE: assert property ($changed(o_csn) |-> $past(i_io.wr))
    else $error("card number changed without write");
  AST_KEY_SLEEP: assert property (($past(o_card_state) == ST_WAIT_KEY
    && o_card_state == ST_SLEEP) |-> $past(i_key_done))
    else $error("left key wait without key");
  AST_IRQ_DECODE: assert property (o_irq_selected == $past(want_irq))
    else $error("interrupt select decode wrong");
  AST_OPEN_DRAIN: assert property (o_irq_open_drain == $past(want_od))
    else $error("interrupt drive decode wrong");
  AST_DMA_DECODE: assert property (o_dma0_active == $past(want_dma))
    else $error("dma channel decode wrong");
endmodule
bind pcr_config_regs pcr_config_regs_sva SVA (.i_clk, .i_rst_n, .i_io, .i_key_done,
  .i_resource_byte, .i_resource_valid, .o_rdata, .o_rdata_valid, .o_card_state, .o_csn,
  .o_read_port, .o_isolation_step, .o_resource_next, .o_resource_rewind, .o_ldev,
  .o_irq_selected, .o_irq_open_drain, .o_dma0_active);
`default_nettype wire

/* bench/pcr_host_model.sv */
// Host bus model for the index and data port pair
`timescale 1ns/1ps
`default_nettype none
module pcr_host_model
  import pcr_pkg::*;
(
  input wire logic i_clk,
  input wire logic [7:0] i_rdata,
  input wire logic i_rdata_valid,
  output var pcr_io_req_t o_io
);
  // ----------------------------------------
  // Bus cycles, launched after the falling edge
  // ----------------------------------------
  initial o_io = '0;
  // Released lines flip so a stale value never looks like a request
  task automatic wr(input logic [15:0] a, input logic [7:0] d);
    @(negedge i_clk);
    o_io.addr = a;
    o_io.wdata = d;
    o_io.wr = 1'b1;
    @(negedge i_clk);
    o_io.wr = 1'b0;
    o_io.addr = ~a;
    o_io.wdata = ~d;
  endtask
  task automatic rd(input logic [15:0] a, output logic [7:0] d, output logic v);
    @(negedge i_clk);
    o_io.addr = a;
    o_io.rd = 1'b1;
    @(negedge i_clk);
    o_io.rd = 1'b0;
    o_io.addr = ~a;
    d = i_rdata;
    v = i_rdata_valid;
  endtask
  task automatic reg_wr(input logic [7:0] idx, input logic [7:0] d);
    wr(MB_INDEX_ADDR, idx);
    wr(MB_DATA_ADDR, d);
  endtask
  task automatic reg_rd(input logic [7:0] idx, output logic [7:0] d, output logic v);
    wr(MB_INDEX_ADDR, idx);
    rd(MB_DATA_ADDR, d, v);
  endtask
  // Status polled, bounded, before the byte is taken
  task automatic res_rd(output logic [7:0] d, output logic ok);
    logic v;
    ok = 1'b0;
    d = 8'h00;
    wr(MB_INDEX_ADDR, IDX_STATUS);
    for (int n = 0; n < 16 && !ok; n++) begin
      rd(MB_DATA_ADDR, d, v);
      ok = v && d[0];
    end
    if (ok) begin
      reg_rd(IDX_RESOURCE, d, v);
    end
  endtask
endmodule
`default_nettype wire

/* bench/test_pcr_config_regs.sv */
// Self-checking testbench for the configuration register file
`timescale 1ns/1ps
`default_nettype none
module test_pcr_config_regs
  import pcr_pkg::*;
;
  logic i_clk, i_rst_n, i_address_strap_high, i_key_done, i_resource_valid;
  logic i_isolation_lost = 1'b0;
  logic [7:0] i_isolation_data, i_resource_byte, o_rdata, o_csn, o_ldn;
  logic o_rdata_valid, o_isolation_step, o_resource_next, o_resource_rewind;
  logic [9:0] o_read_port;
  pcr_io_req_t i_io;
  pcr_state_t o_card_state;
  pcr_ldev_t [LDEV_COUNT-1:0] o_ldev;
  logic [LDEV_COUNT-1:0] o_irq_selected, o_irq_open_drain, o_dma0_active, o_dma1_active;
  int mismatches, cmp_count;

  pcr_config_regs DUT (.i_clk, .i_rst_n, .i_address_strap_high, .i_io, .i_key_done,
    .i_isolation_lost, .i_isolation_data, .i_resource_byte, .i_resource_valid, .o_rdata,
    .o_rdata_valid, .o_card_state, .o_csn, .o_ldn, .o_read_port, .o_isolation_step,
    .o_resource_next, .o_resource_rewind, .o_ldev, .o_irq_selected, .o_irq_open_drain,
    .o_dma0_active, .o_dma1_active);
  pcr_host_model HOST (.i_clk, .i_rdata(o_rdata), .i_rdata_valid(o_rdata_valid), .o_io(i_io));

  // ----------------------------------------
  // Helpers
  // ----------------------------------------
  initial begin
    i_clk = 1'b0;
    forever #12.5 i_clk = ~i_clk;
  end
  task automatic chk(input logic [15:0] got, input logic [15:0] exp);
    cmp_count++;
    if (got !== exp) begin
      mismatches++;
      $display("ERROR %0t: got %h expected %h", $time, got, exp);
    end
  endtask
  task automatic rd_chk(input logic [7:0] idx, input logic [7:0] exp);
    logic [7:0] d;
    logic v;
    HOST.reg_rd(idx, d, v);
    chk({v, d}, {1'b1, exp});
  endtask
  task automatic do_reset(input logic strap);
    @(negedge i_clk);
    i_address_strap_high = strap;
    i_rst_n = 1'b0;
    repeat (3) @(negedge i_clk);
    i_rst_n = 1'b1;
    repeat (2) @(negedge i_clk);
  endtask
  task automatic end_sim;
    $display("Comparisons %0d, mismatches %0d", cmp_count, mismatches);
    if (mismatches == 0 && cmp_count > 0) begin
      $display("All checks passed");
    end else begin
      $display("Checks failed");
    end
    $finish;
  endtask

  // ----------------------------------------
  // Scenarios
  // ----------------------------------------
  task automatic t_pnp;
    logic [7:0] d;
    logic v;
    do_reset(1'b0);
    chk(o_card_state, ST_WAIT_KEY);
    HOST.wr(16'h0279, IDX_WAKE);
    HOST.wr(16'h0A79, 8'h00);
    chk(o_card_state, ST_WAIT_KEY);
    i_key_done = 1'b1;
    @(negedge i_clk);
    i_key_done = 1'b0;
    chk(o_card_state, ST_SLEEP);
    HOST.wr(16'h0A79, 8'h00);
    chk(o_resource_rewind, 1'b1);
    chk(o_card_state, ST_ISOLATION);
    HOST.wr(16'h0279, IDX_RDPORT);
    HOST.wr(16'h0A79, 8'h80);
    chk(o_read_port, 10'h203);
    i_isolation_data = 8'h5A;
    HOST.wr(16'h0279, IDX_SERIAL_ISO);
    HOST.rd(16'h0203, d, v);
    chk({v, d}, 9'h15A);
    chk(o_isolation_step, 1'b1);
    HOST.wr(16'h0279, IDX_CSN);
    HOST.wr(16'h0A79, 8'h05);
    chk(o_csn, 8'h05);
    HOST.wr(16'h0279, IDX_WAKE);
    HOST.wr(16'h0A79, 8'h07);
    chk(o_card_state, ST_SLEEP);
    HOST.wr(16'h0A79, 8'h05);
    chk(o_card_state, ST_CONFIG);
    HOST.wr(16'h0279, IDX_CFG_CTRL);
    HOST.wr(16'h0A79, 8'h02);
    chk(o_card_state, ST_WAIT_KEY);
    chk(o_csn, 8'h05);
  endtask
  task automatic t_ldev_regs;
    logic [7:0] d;
    logic v;
    logic [3:0] ld;
    HOST.wr(MB_INDEX_ADDR, 8'h31);
    HOST.rd(MB_INDEX_ADDR, d, v);
    chk({v, d}, 9'h131);
    rd_chk(8'h40, 8'h00);
    for (int p = 0; p < 4; p++) begin
      ld = p[0] ? 4'h8 : 4'h0;
      HOST.reg_wr(IDX_LDN, {4'h0, ld});
      for (int k = 0; k < 4; k++) begin
        if (p < 2) begin
          HOST.reg_wr(IDX_BASE0_HI + 8'(k), {ld, 2'b00, 2'(k)});
        end else begin
          rd_chk(IDX_BASE0_HI + 8'(k), {ld, 2'b00, 2'(k)});
        end
      end
    end
    chk(o_ldev[8].base0, 16'h8081);
    HOST.reg_wr(IDX_ACTIVATE, 8'hFF);
    rd_chk(IDX_ACTIVATE, 8'h01);
    chk(o_ldev[8].active, 1'b1);
    HOST.reg_wr(IDX_RANGE_CHK, 8'hFF);
    rd_chk(IDX_RANGE_CHK, 8'h03);
  endtask
  // Decodes trail the register by one cycle, hence the extra edge
  task automatic t_decode;
    for (int i = 0; i < 8; i++) begin
      HOST.reg_wr(IDX_IRQ_LEVEL, 8'(i * 5 % 20));
      HOST.reg_wr(IDX_IRQ_TYPE, 8'(i % 4));
      HOST.reg_wr(IDX_DMA0, 8'(i));
      HOST.reg_wr(IDX_DMA1, 8'(7 - i));
      @(negedge i_clk);
      chk(o_irq_selected[8], (i % 4) != 0);
      chk(o_irq_open_drain[8], (i % 4) < 2);
      chk(o_dma0_active[8], i != 4);
      chk(o_dma1_active[8], i != 3);
    end
  endtask
  task automatic t_range;
    logic [7:0] d;
    logic v;
    HOST.reg_wr(IDX_LDN, 8'h01);
    HOST.reg_wr(IDX_BASE0_HI, 8'h03);
    HOST.reg_wr(IDX_BASE0_LO, 8'h00);
    HOST.reg_wr(IDX_RANGE_CHK, 8'h03);
    HOST.rd(16'h0307, d, v);
    chk({v, d}, 9'h155);
    HOST.reg_wr(IDX_RANGE_CHK, 8'h02);
    HOST.rd(16'h0300, d, v);
    chk({v, d}, 9'h1AA);
    HOST.rd(16'h0308, d, v);
    chk(v, 1'b0);
    HOST.reg_wr(IDX_RANGE_CHK, 8'h00);
    HOST.reg_wr(IDX_ACTIVATE, 8'h01);
    HOST.reg_wr(IDX_RANGE_CHK, 8'h03);
    HOST.rd(16'h0300, d, v);
    chk(v, 1'b0);
  endtask
  task automatic t_res_ctrl;
    logic [7:0] d;
    logic ok;
    i_resource_byte = 8'hC3;
    rd_chk(IDX_STATUS, 8'h00);
    i_resource_valid = 1'b1;
    HOST.res_rd(d, ok);
    chk({ok, d}, 9'h1C3);
    chk(o_resource_next, 1'b1);
    rd_chk(IDX_WAKE, 8'h00);
    HOST.reg_wr(IDX_CSN, 8'h09);
    HOST.reg_wr(IDX_CFG_CTRL, 8'h01);
    chk(o_ldev[1] === LDEV_DEFAULT, 1'b1);
    chk(o_csn, 8'h09);
    chk(o_ldn, 8'h00);
    rd_chk(IDX_CFG_CTRL, 8'h00);
    HOST.reg_wr(IDX_CFG_CTRL, 8'h04);
    chk(o_csn, 8'h00);
  endtask

  // ----------------------------------------
  // Main sequence and hang guard
  // ----------------------------------------
  initial begin
    i_rst_n = 1'b0;
    i_address_strap_high = 1'b0;
    i_key_done = 1'b0;
    i_isolation_data = 8'h00;
    i_resource_byte = 8'h00;
    i_resource_valid = 1'b0;
    mismatches = 0;
    cmp_count = 0;
    t_pnp;
    do_reset(1'b1);
    chk(o_card_state, ST_CONFIG);
    t_ldev_regs;
    t_decode;
    t_range;
    t_res_ctrl;
    end_sim;
  end
  initial begin
    repeat (20000) @(posedge i_clk);
    mismatches++;
    $display("ERROR %0t: run timed out", $time);
    end_sim;
  end
endmodule
`default_nettype wire
